//--- quad_store_pkg.sv
// quad_store_pkg: widths and reset values shared by the four-bit bus
// register and its storage cell.
// assumes a single clock domain; no timing counts are needed.
package quad_store_pkg;

  // number of independent stored bits
  localparam int unsigned DATA_WIDTH = 4;

  // value held after clear or reset
  localparam logic STORE_RESET = 1'b0;

  // bus drive state after reset: released
  localparam logic [DATA_WIDTH-1:0] DRIVE_RESET = 4'h0;

  // bus drive pattern while the outputs are enabled
  localparam logic [DATA_WIDTH-1:0] DRIVE_ALL = 4'hf;

  // bus drive pattern while the outputs are released
  localparam logic [DATA_WIDTH-1:0] DRIVE_NONE = 4'h0;

endpackage

//--- store_bit_cell.sv
// store_bit_cell: one stored bit with load, hold and direct clear.
// assumes load_in and data_in come from logic on clock_in; clear_in
// may arrive at any time and acts without the clock.
`timescale 1ns/10ps

module store_bit_cell
  import quad_store_pkg::*;
(
  // clock and resets
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clear_in,
  // load path
  input wire logic load_in,
  input wire logic data_in,
  // stored level
  output logic bit_out
);

  typedef struct packed {
    logic bit_q;
  } cell_state_t;

  cell_state_t state_q;
  cell_state_t state_d;

  always_comb begin
    state_d = state_q;
    // hold unless the load pair is active at this edge
    if (load_in) begin
      state_d.bit_q = data_in; // R2
    end
  end

  // the clear is taken straight into the flop so it does not wait
  // for an edge; it wins over load, data and reset alike
  always_ff @(posedge clock_in or posedge clear_in) begin
    if (clear_in) begin
      state_q <= '{bit_q: STORE_RESET}; // R4
    end else if (rst_in) begin
      state_q <= '{bit_q: STORE_RESET};
    end else begin
      state_q <= state_d; // R3
    end
  end

  assign bit_out = state_q.bit_q;

endmodule // store_bit_cell

//--- quad_d_register_tristate_out.sv
// quad_d_register_tristate_out: four-bit storage register that feeds a
// shared on-chip bus through per-bit drive enables.
// assumes all inputs come from logic on clock_in; clear_in is a direct
// clear and acts without the clock; the bus wire is resolved outside.
//
// How it works
// (R1) four independent bits, each own input, output
// (R2) both load enables low: capture on edge
// (R3) otherwise every stored bit holds its level
// (R4) clear high zeroes all bits, no clock
// (R5) both drive enables low: bits drive bus
// (R6) either drive enable high: bus released
// (R7) release never disturbs load, hold or clear
// (R8) bus owner enables one driver at once
`timescale 1ns/10ps

module quad_d_register_tristate_out
  import quad_store_pkg::*;
(
  // clock and resets
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clear_in,
  // load control, active low, both needed
  input wire logic load_enable_a_n_in,
  input wire logic load_enable_b_n_in,
  // parallel data
  input wire logic [DATA_WIDTH-1:0] data_in,
  // drive control, active low, both needed
  input wire logic drive_enable_a_n_in,
  input wire logic drive_enable_b_n_in,
  // bus side: level and per-bit output enable
  output logic [DATA_WIDTH-1:0] data_out,
  output logic [DATA_WIDTH-1:0] data_oe_out
);

  ////////////////////////////////////////////////////////////////////
  // decoding shared by the load pair and the drive pair

  function automatic logic pair_active(input logic a_n, input logic b_n);
    pair_active = ~a_n & ~b_n;
  endfunction

  typedef struct packed {
    logic [DATA_WIDTH-1:0] drive_q;
  } bus_state_t;

  bus_state_t state_q;
  bus_state_t state_d;

  logic load_enable_pair_n;
  logic load_now;
  logic drive_now;
  logic [DATA_WIDTH-1:0] stored;

  assign load_enable_pair_n = ~pair_active(load_enable_a_n_in,
                                           load_enable_b_n_in);
  assign load_now = ~load_enable_pair_n;
  assign drive_now = pair_active(drive_enable_a_n_in,
                                 drive_enable_b_n_in);

  ////////////////////////////////////////////////////////////////////
  // storage: one cell per bit, load shared, data per bit

  // the cells see only the clock, reset, clear, load pair and data, never
  // the drive pair, so releasing the bus cannot touch what is stored
  genvar gi;
  generate
    for (gi = 0; gi < DATA_WIDTH; gi++) begin : g_bit
      store_bit_cell u_cell (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .clear_in (clear_in),
        .load_in  (load_now),   // R2
        .data_in  (data_in[gi]),
        .bit_out  (stored[gi])  // R1
      );
    end
  endgenerate

  // the stored level is always presented; the enable decides whether
  // it reaches the bus
  assign data_out = stored; // R7

  ////////////////////////////////////////////////////////////////////
  // bus drive enable

  // registered so the enable leaves from a flop; this costs one cycle
  // between the drive pair changing and the bus following it
  always_comb begin
    state_d = state_q;
    if (drive_now) begin
      state_d.drive_q = DRIVE_ALL;  // R5
    end else begin
      state_d.drive_q = DRIVE_NONE; // R6
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= '{drive_q: DRIVE_RESET};
    end else begin
      state_q <= state_d;
    end
  end

  assign data_oe_out = state_q.drive_q;

  ////////////////////////////////////////////////////////////////////
  // checks

  // a load with differing end bits must leave them differing
  AST_BITS_INDEPENDENT: assert property ( // R1
    @(posedge clock_in) disable iff (rst_in || clear_in)
    (load_now && (data_in[0] != data_in[DATA_WIDTH-1]))
    |=> (data_out[0] != data_out[DATA_WIDTH-1]))
  else $error("stored bits are not independent");

  AST_LOAD_CAPTURES: assert property ( // R2
    @(posedge clock_in) disable iff (rst_in || clear_in)
    load_now |=> (data_out == $past(data_in)))
  else $error("load pair active but data not captured");

  AST_HOLD_WITHOUT_LOAD: assert property ( // R3
    @(posedge clock_in) disable iff (rst_in || clear_in)
    (!load_now && !$past(clear_in)) ##1 !load_now
    |=> $stable(data_out))
  else $error("stored value changed without a load");

  AST_CLEAR_ZEROES: assert property ( // R4
    @(posedge clock_in) disable iff (rst_in)
    (clear_in && $past(clear_in)) |-> (data_out == '0))
  else $error("clear held but stored bits not zero");

  AST_CLEAR_BEATS_LOAD: assert property ( // R4
    @(posedge clock_in) disable iff (rst_in)
    (clear_in && load_now && (data_in != '0)) ##1 clear_in
    |-> (data_out == '0))
  else $error("load overrode the clear");

  AST_DRIVE_ON: assert property ( // R5
    @(posedge clock_in) disable iff (rst_in)
    drive_now |=> (data_oe_out == DRIVE_ALL))
  else $error("drive pair active but bus not driven");

  AST_DRIVE_OFF: assert property ( // R6
    @(posedge clock_in) disable iff (rst_in)
    !drive_now |=> (data_oe_out == DRIVE_NONE))
  else $error("a drive enable high but bus still driven");

  AST_LOAD_WHILE_RELEASED: assert property ( // R7
    @(posedge clock_in) disable iff (rst_in || clear_in)
    (!drive_now && load_now) ##1 !drive_now
    |-> (data_out == $past(data_in)) && (data_oe_out == DRIVE_NONE))
  else $error("release disturbed loading");

  AST_HOLD_WHILE_RELEASED: assert property ( // R7
    @(posedge clock_in) disable iff (rst_in || clear_in)
    (!load_now && !drive_now) |=> $stable(data_out))
  else $error("stored value moved while the bus was released");

  AST_CLEAR_WHILE_RELEASED: assert property ( // R7
    @(posedge clock_in) disable iff (rst_in)
    (clear_in && !drive_now) |-> (data_out == '0))
  else $error("clear lost while the bus was released");

  // clear acts on storage only; the bus keeps its drive state
  AST_CLEAR_KEEPS_DRIVE: assert property ( // R5
    @(posedge clock_in) disable iff (rst_in)
    (clear_in && drive_now) |=> (data_oe_out == DRIVE_ALL))
  else $error("clear disturbed the bus drive");

  // one load enable low on its own is not a load
  AST_LOAD_NEEDS_BOTH: assert property ( // R3
    @(posedge clock_in) disable iff (rst_in || clear_in)
    (load_enable_a_n_in != load_enable_b_n_in) |=> $stable(data_out))
  else $error("a single load enable loaded the register");

  // one drive enable low on its own must not drive the bus
  AST_DRIVE_NEEDS_BOTH: assert property ( // R6
    @(posedge clock_in) disable iff (rst_in)
    (drive_enable_a_n_in != drive_enable_b_n_in)
    |=> (data_oe_out == DRIVE_NONE))
  else $error("a single drive enable drove the bus");

  // per-bit views, so one stuck or crossed bit cannot hide behind the
  // word compares above
  generate
    for (gi = 0; gi < DATA_WIDTH; gi++) begin : g_bit_chk
      AST_BIT_OWN_INPUT: assert property ( // R1
        @(posedge clock_in) disable iff (rst_in || clear_in)
        load_now |=> (data_out[gi] == $past(data_in[gi])))
      else $error("a stored bit did not follow its own input");

      AST_BIT_HOLD: assert property ( // R3
        @(posedge clock_in) disable iff (rst_in || clear_in)
        !load_now |=> $stable(data_out[gi]))
      else $error("a stored bit moved without a load");

      AST_BIT_CLEAR: assert property ( // R4
        @(posedge clock_in) disable iff (rst_in)
        clear_in |-> (data_out[gi] == STORE_RESET))
      else $error("a stored bit survived the clear");
    end
  endgenerate

  COV_LOAD_AND_DRIVE: cover property (
    @(posedge clock_in) disable iff (rst_in || clear_in)
    load_now ##1 drive_now ##1 (data_oe_out == DRIVE_ALL));

  COV_LOAD_WHILE_RELEASED: cover property (
    @(posedge clock_in) disable iff (rst_in || clear_in)
    (!drive_now && load_now) ##1 (data_out != '0));

  COV_CLEAR_AFTER_LOAD: cover property (
    @(posedge clock_in) disable iff (rst_in)
    (load_now && (data_in != '0)) ##1 clear_in ##1 (data_out == '0));

  COV_CLEAR_WHILE_RELEASED: cover property (
    @(posedge clock_in) disable iff (rst_in)
    (clear_in && !drive_now) ##1 clear_in);

  COV_RELEASE_AFTER_DRIVE: cover property (
    @(posedge clock_in) disable iff (rst_in || clear_in)
    ((data_oe_out == DRIVE_ALL) && !drive_now)
    ##1 (data_oe_out == DRIVE_NONE));

endmodule // quad_d_register_tristate_out

//--- bus_owner_model.sv
// bus_owner_model: the shared bus and its second source.
// assumes the register's level and per-bit enable come straight in.
`timescale 1ns/10ps
module bus_owner_model (
  // register side
  input wire logic [3:0] level_in,
  input wire logic [3:0] oe_in,
  // second source
  input wire logic [3:0] other_in,
  input wire logic other_req_in,
  // resolved bus
  output logic [3:0] bus_out
);
  // nothing driving: show the inverse, so a stale value cannot pass
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (oe_in[i])
        bus_out[i] = level_in[i];
      else if (other_req_in)
        bus_out[i] = other_in[i];
      else
        bus_out[i] = ~level_in[i];
    end
  end
endmodule // bus_owner_model

//--- quad_d_register_tristate_out_tb.sv
// quad_d_register_tristate_out_tb: load, hold, clear and bus drive.
// assumes bus_owner_model grants the bus only while released.
`timescale 1ns/10ps
module quad_d_register_tristate_out_tb;
  import quad_store_pkg::*;
  logic clock_in, rst_in, clear_in, lea_n, leb_n, dea_n, deb_n, oreq;
  logic [3:0] din, other, dout, doe, bus;
  int fail_count = 0;
  int cmp_count = 0;
  quad_d_register_tristate_out u_quad_d_register_tristate_out (
    .clock_in(clock_in), .rst_in(rst_in), .clear_in(clear_in),
    .load_enable_a_n_in(lea_n), .load_enable_b_n_in(leb_n),
    .data_in(din), .drive_enable_a_n_in(dea_n),
    .drive_enable_b_n_in(deb_n), .data_out(dout), .data_oe_out(doe));
  bus_owner_model u_bus_owner_model (.level_in(dout), .oe_in(doe),
    .other_in(other), .other_req_in(oreq), .bus_out(bus));
  ////////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge clock_in);
    #1;
  endtask
  task automatic chk(string name, logic [3:0] got, logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_load();
    {lea_n, leb_n, din} = {2'b00, 4'ha};
    step();
    chk("load", dout, 4'ha);
    din = 4'h5;
    step();
    chk("load2", dout, 4'h5);
  endtask
  task automatic t_hold();
    for (int k = 1; k < 4; k++) begin
      {lea_n, leb_n} = k[1:0];
      din = 4'h3;
      step();
      chk("hold", dout, 4'h5);
    end
  endtask
  task automatic t_clear();
    {lea_n, leb_n, din} = {2'b00, 4'hf};
    step();
    clear_in = 1'b1;
    #2;
    chk("clr", dout, 4'h0);
    step();
    chk("clr_edge", dout, 4'h0);
    step();
    chk("clr_hold", dout, 4'h0);
    clear_in = 1'b0;
  endtask
  task automatic t_drive();
    {dea_n, deb_n, din} = {2'b00, 4'h9};
    step();
    chk("oe", doe, DRIVE_ALL);
    chk("bus", bus, 4'h9);
    for (int k = 1; k < 4; k++) begin
      {dea_n, deb_n} = k[1:0];
      step();
      {oreq, other, din} = {1'b1, 4'h6, 4'hc};
      step();
      chk("oe_off", doe, DRIVE_NONE);
      chk("bus_oth", bus, 4'h6);
      chk("ld_off", dout, 4'hc);
      {dea_n, deb_n, oreq} = 3'h0;
      step();
    end
    clear_in = 1'b1;
    step();
    chk("clr_oe", doe, DRIVE_ALL);
    chk("clr_bus", bus, 4'h0);
    clear_in = 1'b0;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    {clear_in, lea_n, leb_n, dea_n, deb_n, oreq} = 6'h1e;
    {din, other} = 8'h00;
    rst_in = 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    chk("rst_oe", doe, DRIVE_RESET);
    chk("rst_q", dout, 4'h0);
    t_load();
    t_hold();
    t_clear();
    t_drive();
    stop_test();
  end
  // the tests need well under 30 cycles
  initial begin
    #2000;
    fail_count++;
    stop_test();
  end
endmodule // quad_d_register_tristate_out_tb
